// >>> tb/aftf_media_model.sv
// Behavioural model of the write cache and the media behind the command block
`timescale 1ns/1ps
module aftf_media_model (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic clr_i,
   input wire logic flush_req_i,
   input wire logic media_wr_i,
   input wire logic [27:0] media_lba_i,
   output logic cache_empty_o,
   output logic media_done_o,
   output logic [7:0] n_wr_o,
   output logic [27:0] first_lba_o,
   output logic [27:0] last_lba_o
);
   logic [4:0] flush_cnt_ff;
   logic [1:0] wr_cnt_ff;
   // Cache drains to the media only after a long delay
   assign cache_empty_o = (flush_cnt_ff == 5'h14);
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flush_cnt_ff <= 5'h00;
         wr_cnt_ff <= 2'h0;
         media_done_o <= 1'b0;
         n_wr_o <= 8'h00;
         first_lba_o <= 28'h0000000;
         last_lba_o <= 28'h0000000;
      end else begin
         media_done_o <= 1'b0;
         if (!flush_req_i) begin
            flush_cnt_ff <= 5'h00;
         end else if (flush_cnt_ff != 5'h14) begin
            flush_cnt_ff <= flush_cnt_ff + 5'h01;
         end
         // Sector writes finish quickly or slowly, with no read-back
         if (media_wr_i && !media_done_o) begin
            if (wr_cnt_ff == (media_lba_i[0] ? 2'h3 : 2'h1)) begin
               media_done_o <= 1'b1;
               wr_cnt_ff <= 2'h0;
               n_wr_o <= n_wr_o + 8'h01;
               last_lba_o <= media_lba_i;
               if (n_wr_o == 8'h00) begin
                  first_lba_o <= media_lba_i;
               end
            end else begin
               wr_cnt_ff <= wr_cnt_ff + 2'h1;
            end
         end
         if (clr_i) begin
            n_wr_o <= 8'h00;
         end
      end
   end
endmodule // aftf_media_model

// >>> tb/tb.sv
// Testbench for the flush and track format command interpreter
`timescale 1ns/1ps
module tb;
   import aftf_pkg::*;
   logic clk, arst_n, wr, rd, tbl_valid, clr;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, n_wr;
   logic cache_empty, flush_req, tbl_ready, media_wr, media_done, busy;
   logic [27:0] media_lba, first_lba, last_lba;
   int n_mismatch = 0;
   int checked = 0;
   aftf_cmd #(.HEADS(8'h02), .SECTORS_PER_TRACK(8'h04), .MAX_LBA(28'h00000ff)) aftf_cmd_i (
      .REF_CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .CACHE_EMPTY_I(cache_empty), .FLUSH_REQ_O(flush_req), .TABLE_VALID_I(tbl_valid),
      .TABLE_READY_O(tbl_ready), .MEDIA_WR_O(media_wr), .MEDIA_LBA_O(media_lba),
      .MEDIA_DONE_I(media_done), .BUSY_O(busy));
   aftf_media_model aftf_media_model_i (
      .clk_i(clk), .arst_n_i(arst_n), .clr_i(clr), .flush_req_i(flush_req), .media_wr_i(media_wr),
      .media_lba_i(media_lba), .cache_empty_o(cache_empty), .media_done_o(media_done), .n_wr_o(n_wr),
      .first_lba_o(first_lba), .last_lba_o(last_lba));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d, input logic t);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      tbl_valid <= t;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(28'(rdata), 28'(exp));
   endtask
   task automatic wait_idle;
      int i;
      i = 0;
      @(posedge clk);
      tbl_valid <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy !== 1'b0 && i < 3000) begin
         @(posedge clk);
         i++;
      end
      #1;
      chk(28'(busy), 28'h0000000);
   endtask
   // Loads the address registers, then issues a command with or without a table
   task automatic issue(input logic [7:0] s, lo, hi, dh, op, input logic t);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      wr_reg(ADR_SECNUM, s, 1'b0);
      wr_reg(ADR_CYL_LO, lo, 1'b0);
      wr_reg(ADR_CYL_HI, hi, 1'b0);
      wr_reg(ADR_DEVHEAD, dh, 1'b0);
      wr_reg(ADR_CMD, op, t);
      #1;
      if (op == OP_FMT_TRACK) chk(28'(tbl_ready), 28'h0000001);
      wait_idle;
   endtask
   task automatic fmt(input logic [7:0] s, lo, dh, input logic [27:0] f, input logic t);
      issue(s, lo, 8'h00, dh, OP_FMT_TRACK, t);
      chk(28'(n_wr), 28'h0000004);
      chk(first_lba, f);
      chk(last_lba, f + 28'h3);
      rd_reg(ADR_ERROR, 8'h00);
      rd_reg(ADR_CMD, STATUS_RESET);
   endtask
   task automatic test_done;
      $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #100us;
      n_mismatch++;
      test_done;
   end
   logic [7:0] ab_lo [3] = '{8'h01, 8'h00, 8'h00};
   logic [7:0] ab_dh [3] = '{8'he0, 8'he1, 8'he0};
   logic [7:0] ab_op [3] = '{OP_FMT_TRACK, OP_FMT_TRACK, 8'h00};
   initial begin
      arst_n = 1'b0;
      {wr, rd, tbl_valid, clr} = 4'h0;
      addr = 3'h0;
      wdata = 8'h00;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      rd_reg(ADR_CMD, STATUS_RESET);
      rd_reg(ADR_DEVHEAD, DH_RESET);
      rd_reg(3'h2, 8'h00);
      rd_reg(ADR_GEOM, 8'h04);
      wr_reg(ADR_CMD, OP_FLUSH, 1'b0);
      repeat (12) @(posedge clk);
      #1;
      chk(28'(busy), 28'h0000001);
      chk(28'(flush_req), 28'h0000001);
      wait_idle;
      rd_reg(ADR_CMD, STATUS_RESET);
      fmt(8'h0a, 8'h00, 8'he0, 28'h0000008, 1'b1);
      rd_reg(ADR_DEVHEAD, 8'he0);
      rd_reg(ADR_SECNUM, 8'h08);
      rd_reg(ADR_CYL_HI, 8'h00);
      fmt(8'h01, 8'h02, 8'ha1, 28'h0000014, 1'b0);
      for (int k = 0; k < 3; k++) begin
         issue(8'h00, ab_lo[k], 8'h00, ab_dh[k], ab_op[k], 1'b0);
         chk(28'(n_wr), 28'h0000000);
         rd_reg(ADR_ERROR, 8'h04);
         rd_reg(ADR_CMD, 8'h51);
      end
      fmt(8'hff, 8'h00, 8'he0, 28'h00000fc, 1'b0);
      test_done;
   end
endmodule // tb

// >>> verilog/aftf_cmd.sv
// Command interpreter for cache flush and track format
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module aftf_cmd
   import aftf_pkg::*;
#(
   parameter logic [7:0] HEADS = 8'h10,
   parameter logic [7:0] SECTORS_PER_TRACK = SPT_DEFAULT,
   parameter logic [27:0] MAX_LBA = MAX_LBA_DEFAULT
)(
   input wire logic REF_CLK_I,
   input wire logic ARST_N_I,
   input wire logic [2:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   input wire logic CACHE_EMPTY_I,
   output logic FLUSH_REQ_O,
   input wire logic TABLE_VALID_I,
   output logic TABLE_READY_O,
   output logic MEDIA_WR_O,
   output logic [27:0] MEDIA_LBA_O,
   input wire logic MEDIA_DONE_I,
   output logic BUSY_O
);
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_FLUSH = 5'b00010,
      S_TABLE = 5'b00100,
      S_FORMAT = 5'b01000,
      S_DONE = 5'b10000
   } aftf_state_t;
   aftf_state_t state_ff, nxt_state;
   logic [7:0] secnum_ff, cyl_lo_ff, cyl_hi_ff, devhead_ff, error_ff, status_ff, rdata_ff;
   logic [7:0] tbl_cnt_ff;
   logic start_ff, flush_ff, busy_ff, wr_ff;
   logic [27:0] mlba_ff;
   logic wr_cmd_w, is_lba_w, out_range_w, fmt_done_w, z_req_w, table_done_w;
   logic [27:0] lba_in_w, chs_lba_w, trk_first_w, cur_lba_w, z_lba_w;
   logic [15:0] cyl_w;
   logic [3:0] head_w;
   logic [7:0] rd_mux_w;
   logic [7:0] err_done_w;
   logic wb_ff;
   logic [7:0] done_cnt_ff;
   // Address decode of the task file
   assign is_lba_w = devhead_ff[DH_LBA];
   assign lba_in_w = {devhead_ff[3:0], cyl_hi_ff, cyl_lo_ff, secnum_ff};
   // Cylinder and head in CHS mode
   assign cyl_w = {cyl_hi_ff, cyl_lo_ff};
   assign head_w = devhead_ff[3:0];
   assign chs_lba_w = 28'((32'(cyl_w) * 32'(HEADS) + 32'(head_w)) * 32'(SECTORS_PER_TRACK));
   // Track holding the given block
   assign trk_first_w = 28'((32'(lba_in_w) / 32'(SECTORS_PER_TRACK)) * 32'(SECTORS_PER_TRACK));
   assign cur_lba_w = is_lba_w ? trk_first_w : chs_lba_w;
   assign out_range_w = is_lba_w ? (lba_in_w > MAX_LBA) : (chs_lba_w > MAX_LBA);
   assign wr_cmd_w = WR_I && (ADDR_I == ADR_CMD) && (state_ff == S_IDLE);
   assign table_done_w = (tbl_cnt_ff == 8'hff) || !TABLE_VALID_I;
   assign err_done_w = out_range_w ? (8'h01 << ERR_ABT) : 8'h00;
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE: begin
            if (wr_cmd_w && WDATA_I == OP_FLUSH) begin
               nxt_state = S_FLUSH;
            end else if (wr_cmd_w && WDATA_I == OP_FMT_TRACK) begin
               nxt_state = S_TABLE;
            end
         end
         S_FLUSH: begin
            if (CACHE_EMPTY_I) begin
               nxt_state = S_DONE;
            end
         end
         S_TABLE: begin
            // Optional table sector drained, then dropped; an out-of-range address goes to done without draining it
            if (out_range_w) begin
               nxt_state = S_DONE;
            end else if (table_done_w) begin
               nxt_state = S_FORMAT;
            end
         end
         S_FORMAT: begin
            if (fmt_done_w) begin
               nxt_state = S_DONE;
            end
         end
         S_DONE: nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end
   aftf_track_zero u_zero (
      .clk_i(REF_CLK_I),
      .arst_n_i(ARST_N_I),
      .start_i(start_ff),
      .first_lba_i(mlba_ff),
      .count_i(SECTORS_PER_TRACK),
      .wr_done_i(MEDIA_DONE_I),
      .wr_req_o(z_req_w),
      .wr_lba_o(z_lba_w),
      .done_o(fmt_done_w)
   );
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_ff <= S_IDLE;
         tbl_cnt_ff <= 8'h00;
         start_ff <= 1'b0;
         mlba_ff <= 28'h0000000;
         wb_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         // Address write-back only after a finished format, never after flush or abort
         wb_ff <= (state_ff == S_FORMAT) && fmt_done_w;
         start_ff <= (state_ff == S_TABLE) && (nxt_state == S_FORMAT);
         if (state_ff == S_TABLE && nxt_state == S_FORMAT) begin
            mlba_ff <= cur_lba_w;
         end
         if (state_ff == S_TABLE && TABLE_VALID_I) begin
            tbl_cnt_ff <= tbl_cnt_ff + 8'h01;
         end else if (state_ff != S_TABLE) begin
            tbl_cnt_ff <= 8'h00;
         end
      end
   end
   // Task file registers written by host while idle
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         secnum_ff <= 8'h00;
         cyl_lo_ff <= 8'h00;
         cyl_hi_ff <= 8'h00;
         devhead_ff <= DH_RESET;
      end else if (wb_ff && is_lba_w) begin
         // Return current LBA split as on input
         secnum_ff <= mlba_ff[7:0];
         cyl_lo_ff <= mlba_ff[15:8];
         cyl_hi_ff <= mlba_ff[23:16];
         devhead_ff[3:0] <= mlba_ff[27:24];
      end else if (WR_I && state_ff == S_IDLE) begin
         case (ADDR_I)
            ADR_SECNUM: secnum_ff <= WDATA_I;
            ADR_CYL_LO: cyl_lo_ff <= WDATA_I;
            ADR_CYL_HI: cyl_hi_ff <= WDATA_I;
            ADR_DEVHEAD: devhead_ff <= WDATA_I | DH_FIXED;
            default: secnum_ff <= secnum_ff;
         endcase
      end
   end
   // Error and status registers
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         error_ff <= 8'h00;
         status_ff <= STATUS_RESET;
         busy_ff <= 1'b0;
         flush_ff <= 1'b0;
         wr_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != S_IDLE) && (nxt_state != S_DONE);
         flush_ff <= (nxt_state == S_FLUSH);
         // Request drops a cycle after each done so no stale address is shown
         wr_ff <= z_req_w && (state_ff == S_FORMAT) && !MEDIA_DONE_I;
         if (wr_cmd_w && (WDATA_I == OP_FLUSH || WDATA_I == OP_FMT_TRACK)) begin
            error_ff <= 8'h00;
            status_ff <= (8'h01 << ST_BSY);
         end else if (wr_cmd_w) begin
            error_ff <= (8'h01 << ERR_ABT);
            status_ff <= (8'h01 << ST_RDY) | (8'h01 << ST_DSC) | 8'h01;
         end else if (state_ff == S_TABLE && out_range_w) begin
            error_ff <= err_done_w;
         end else if (state_ff == S_DONE) begin
            // BSY, DF and COR zero, ERR tracks error register
            status_ff <= (8'h01 << ST_RDY) | (8'h01 << ST_DSC) | {7'h00, (error_ff != 8'h00)};
         end
      end
   end
   assign rd_mux_w = (ADDR_I == ADR_ERROR) ? error_ff :
                     (ADDR_I == ADR_SECNUM) ? secnum_ff :
                     (ADDR_I == ADR_CYL_LO) ? cyl_lo_ff :
                     (ADDR_I == ADR_CYL_HI) ? cyl_hi_ff :
                     (ADDR_I == ADR_DEVHEAD) ? devhead_ff :
                     (ADDR_I == ADR_CMD) ? status_ff :
                     (ADDR_I == ADR_GEOM) ? SECTORS_PER_TRACK : 8'h00;
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rdata_ff <= 8'h00;
      end else if (RD_I) begin
         rdata_ff <= rd_mux_w;
      end else begin
         rdata_ff <= 8'h00;
      end
   end
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         MEDIA_LBA_O <= 28'h0000000;
         TABLE_READY_O <= 1'b0;
      end else begin
         MEDIA_LBA_O <= z_lba_w;
         TABLE_READY_O <= (nxt_state == S_TABLE);
      end
   end
   assign RDATA_O = rdata_ff;
   assign FLUSH_REQ_O = flush_ff;
   assign MEDIA_WR_O = wr_ff;
   assign BUSY_O = busy_ff;
   a_flush_waits_cache: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      state_ff == S_FLUSH && !CACHE_EMPTY_I |=> state_ff == S_FLUSH)
      else $error("Flush completed with data still cached");
   a_fmt_opcode_starts: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      wr_cmd_w && WDATA_I == OP_FMT_TRACK |=> state_ff == S_TABLE)
      else $error("Track format opcode not decoded");
   a_abort_range: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      state_ff == S_TABLE && out_range_w |=> error_ff[ERR_ABT] ##1 status_ff[ST_ERR])
      else $error("Out of range address not aborted");
   a_lba_returned: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      wb_ff && is_lba_w |=> secnum_ff == $past(mlba_ff[7:0]))
      else $error("Current address not returned");
   a_done_status: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      state_ff == S_DONE |=> !status_ff[ST_BSY] && !status_ff[ST_DF] && !status_ff[ST_COR])
      else $error("Completion status wrong");
   a_devhead_fixed: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      devhead_ff[7] && devhead_ff[5])
      else $error("Device head fixed bits not one");
   a_track_aligned: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      start_ff |-> 32'(mlba_ff) % 32'(SECTORS_PER_TRACK) == 0)
      else $error("Format start not track aligned");
   a_table_ignored: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      start_ff |-> mlba_ff == $past(cur_lba_w))
      else $error("Table changed the track");
   c_flush: cover property (@(posedge REF_CLK_I) state_ff == S_FLUSH ##1 state_ff == S_DONE);
   c_format: cover property (@(posedge REF_CLK_I) fmt_done_w);
   c_abort: cover property (@(posedge REF_CLK_I) state_ff == S_TABLE && out_range_w);
   c_chs_format: cover property (@(posedge REF_CLK_I) start_ff && !is_lba_w);
   c_table_beat: cover property (@(posedge REF_CLK_I) state_ff == S_TABLE && TABLE_VALID_I);
   // Sectors accepted in the running format
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         done_cnt_ff <= 8'h00;
      end else if (start_ff) begin
         done_cnt_ff <= 8'h00;
      end else if (z_req_w && MEDIA_DONE_I) begin
         done_cnt_ff <= done_cnt_ff + 8'h01;
      end
   end
   a_sectors_all: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      fmt_done_w |-> done_cnt_ff == SECTORS_PER_TRACK)
      else $error("Format ended before every sector was zeroed");
   a_lba_in_track: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      MEDIA_WR_O |-> (MEDIA_LBA_O - mlba_ff) < 28'(SECTORS_PER_TRACK))
      else $error("Zero write outside the addressed track");
   a_no_stray_write: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      state_ff != S_FORMAT |=> !MEDIA_WR_O)
      else $error("Media write outside a format");
   a_interleave_order: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      MEDIA_WR_O && MEDIA_DONE_I |-> ##2 (!MEDIA_WR_O || MEDIA_LBA_O == $past(MEDIA_LBA_O, 2) + 28'h0000001))
      else $error("Sectors not zeroed in order");
   a_block_in_track: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      start_ff && is_lba_w |-> (lba_in_w - mlba_ff) < 28'(SECTORS_PER_TRACK))
      else $error("Formatted track does not hold the block");
   a_table_offered: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      state_ff == S_TABLE |-> TABLE_READY_O)
      else $error("Table phase without ready");
   a_table_bounded: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      state_ff == S_TABLE && tbl_cnt_ff == 8'hff |=> state_ff != S_TABLE)
      else $error("Table phase longer than one sector");
   a_flush_busy: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      state_ff == S_FLUSH |-> FLUSH_REQ_O && BUSY_O)
      else $error("Flush wait without request or busy");
   a_abort_no_write: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      state_ff == S_TABLE && out_range_w |=> !start_ff && state_ff == S_DONE)
      else $error("Out of range track was formatted");
   a_busy_status: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      BUSY_O |-> status_ff[ST_BSY])
      else $error("Busy command without busy status");
   a_err_follows: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      state_ff == S_IDLE && $past(state_ff) == S_DONE |-> status_ff[ST_ERR] == (error_ff != 8'h00))
      else $error("Error status bit does not follow error register");
   a_unknown_refused: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      wr_cmd_w && WDATA_I != OP_FLUSH && WDATA_I != OP_FMT_TRACK
      |=> state_ff == S_IDLE && error_ff[ERR_ABT] && status_ff[ST_ERR])
      else $error("Unknown opcode not aborted");
   a_cmd_clears: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      wr_cmd_w && (WDATA_I == OP_FLUSH || WDATA_I == OP_FMT_TRACK) |=> error_ff == 8'h00 && status_ff[ST_BSY])
      else $error("New command did not clear error");
   a_regs_locked: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      BUSY_O |=> $stable(secnum_ff) && $stable(cyl_lo_ff) && $stable(cyl_hi_ff) && $stable(devhead_ff))
      else $error("Address changed during a command");
   a_rdata_idle: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      !RD_I |=> RDATA_O == 8'h00)
      else $error("Read data without read strobe");
   a_rdata_status: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      RD_I && ADDR_I == ADR_CMD |=> RDATA_O == $past(status_ff))
      else $error("Status read returned wrong value");
endmodule // aftf_cmd

// >>> verilog/aftf_pkg.sv
// Package with register map, bit fields, reset values and geometry defaults of the flush and track format block
package aftf_pkg;
   localparam logic [7:0] OP_FLUSH = 8'hea;
   localparam logic [7:0] OP_FMT_TRACK = 8'h50;
   localparam logic [2:0] ADR_ERROR = 3'h1;
   localparam logic [2:0] ADR_SECNUM = 3'h3;
   localparam logic [2:0] ADR_CYL_LO = 3'h4;
   localparam logic [2:0] ADR_CYL_HI = 3'h5;
   localparam logic [2:0] ADR_DEVHEAD = 3'h6;
   localparam logic [2:0] ADR_CMD = 3'h7;
   localparam logic [2:0] ADR_GEOM = 3'h0;
   localparam int ERR_ABT = 2;
   localparam int ERR_IDN = 4;
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DF = 5;
   localparam int ST_DSC = 4;
   localparam int ST_COR = 2;
   localparam int ST_ERR = 0;
   localparam int DH_LBA = 6;
   localparam int DH_DEV = 4;
   localparam logic [7:0] DH_FIXED = 8'ha0;
   localparam logic [7:0] DH_RESET = 8'ha0;
   localparam logic [7:0] STATUS_RESET = 8'h50;
   localparam logic [7:0] SPT_DEFAULT = 8'h3f;
   localparam logic [27:0] MAX_LBA_DEFAULT = 28'h0ffffff;
endpackage

// >>> verilog/aftf_track_zero.sv
// Zero-fill sequencer that writes every sector of one track, with no read-back
`timescale 1ns/1ps
module aftf_track_zero
   import aftf_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic start_i,
   input wire logic [27:0] first_lba_i,
   input wire logic [7:0] count_i,
   input wire logic wr_done_i,
   output logic wr_req_o,
   output logic [27:0] wr_lba_o,
   output logic done_o
);
   logic [7:0] left_ff;
   logic busy_ff;
   logic [27:0] lba_ff;
   logic last_w;
   assign last_w = (left_ff == 8'h01);
   assign wr_req_o = busy_ff;
   assign wr_lba_o = lba_ff;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_ff <= 1'b0;
         left_ff <= 8'h00;
         lba_ff <= 28'h0000000;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i && !busy_ff) begin
            // Sectors taken in order, 1:1 interleave
            busy_ff <= 1'b1;
            left_ff <= count_i;
            lba_ff <= first_lba_i;
         end else if (busy_ff && wr_done_i) begin
            // Next sector written with no verify pass
            lba_ff <= lba_ff + 28'h0000001;
            left_ff <= left_ff - 8'h01;
            if (last_w) begin
               busy_ff <= 1'b0;
               done_o <= 1'b1;
            end
         end
      end
   end
   a_one_track_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      busy_ff && wr_done_i && last_w |=> !busy_ff && done_o)
      else $error("Sequencer ran past the track");
endmodule // aftf_track_zero
